// *** hw/eeprom_access_controller.sv ***
/*
 * eeprom_access_controller.sv: io-space registers that let the core read and
 * write single bytes of the on-chip store, with timed write and stalls.
 * The cell array and the oscillator tick divider are instantiated here; the
 * write time is counted in oscillator ticks, so a short count suits simulation.
 * Assumes the core presents one io access per cycle, honours stall_cpu, and
 * reports self-programming and the global interrupt flag as same-clock levels.
 */
// How it works
// - bytes addressed linearly by 11 bits; address bits 15:11 read zero.
// - address register has no reset; host loads it before any access.
// - a write programs the value register byte at the held address.
// - a read loads the value register from the byte at the held address.
// - control bits: ready enable 3, master enable 2, write 1, read 0.
// - ready interrupt held while enable, global flag set and write strobe zero.
// - write strobe starts a write only while master enable is one.
// - master enable clears itself four cycles after software sets it.
// - no write starts while flash self-programming is busy.
// - write strobe clears itself when the write time has elapsed.
// - a started write stalls the core for two cycles.
// - a read completes at once and stalls the core four cycles.
// - during a write, reads are refused and the address is frozen.
// - write lasts 27,072 oscillator cycles, typically 3.4 ms.
// - io offsets 0x00-0x3F, data space adds 0x20; 0x60-0xFF data only.
// - bit set/clear at 0x00-0x1F touch only the addressed bit.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_access_defines.svh"
module eeprom_access_controller
	import eeprom_access_pkg::*;
#(
	parameter int DEPTH = 2048,
	parameter int OSC_DIV = 5,
	parameter int WRITE_OSC_CYCLES = `WRITE_OSC_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic io_sel,
	input wire logic mem_sel,
	input wire logic [7:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic io_bit_set,
	input wire logic io_bit_clr,
	input wire logic [2:0] io_bit,
	input wire logic [7:0] io_wdata,
	input wire logic global_int_enable,
	input wire logic self_program_busy,
	output logic [7:0] io_rdata,
	output logic io_hit,
	output logic stall_cpu,
	output logic ready_irq
);
	localparam int AW = `ADDR_WIDTH;

	typedef struct packed {
		access_state_t state;
		logic [AW-1:0] byte_address_field;
		logic [7:0] byte_value;
		logic ready_interrupt_enable;
		logic master_write_enable;
		logic write_strobe;
		logic read_strobe;
		logic [2:0] master_cnt;
		logic [2:0] stall_cnt;
		logic [15:0] osc_cnt;
		logic [7:0] rdata;
		logic hit;
		logic stall;
		logic irq;
	} state_t;

	state_t s_r;
	state_t s_nxt;
	logic osc_tick;
	logic [7:0] cell_rdata;
	logic cell_rd;
	logic cell_wr;
	logic [5:0] off;
	logic sel;
	io_op_t op;
	logic [7:0] ctl_now;
	logic [7:0] ctl_new;
	logic ctl_acc;
	logic go_write;
	logic go_read;

	// maps a bus cycle to an io offset; io vs data space
	function automatic logic [6:0] io_offset(input logic is_io, input logic is_mem, input logic [7:0] a);
		logic [7:0] d;
		d = a - `IO_DATA_SPACE_SHIFT;
		if (is_io && a <= `IO_SPACE_LAST) begin
			return {1'b1, a[5:0]};
		end
		if (is_mem && a >= `IO_DATA_SPACE_SHIFT && a < `EXT_IO_FIRST) begin
			return {1'b1, d[5:0]};
		end
		return 7'h00;
	endfunction : io_offset

	function automatic logic [7:0] ctl_view(input state_t s);
		return {4'h0, s.ready_interrupt_enable, s.master_write_enable, s.write_strobe, s.read_strobe};
	endfunction : ctl_view

	// one of the four registers this block answers
	function automatic logic reg_mapped(input logic [5:0] o);
		return o == `OFS_CONTROL || o == `OFS_VALUE || o == `OFS_ADDR_LOW || o == `OFS_ADDR_HIGH;
	endfunction : reg_mapped

	// any write or single-bit change aimed at the control register
	function automatic logic ctl_touch(input io_op_t o, input logic [5:0] a);
		return o != IO_NONE && a == `OFS_CONTROL;
	endfunction : ctl_touch

	// single-bit access is decoded only on the lower io page
	function automatic logic bit_page(input logic is_io, input logic [7:0] a);
		return is_io && a <= `IO_BIT_SPACE_LAST;
	endfunction : bit_page

	// ticks run only while a write is being timed
	osc_tick_divider #(
		.DIV(OSC_DIV)
	) u_div (
		.ref_clk(ref_clk),
		.rst(rst),
		.run(s_r.state == ST_WRITE),
		.tick(osc_tick)
	);

	// cells answer a read one cycle after the strobe, hence the read state
	eeprom_cell_array #(
		.ADDR_W(AW),
		.DEPTH(DEPTH)
	) u_cells (
		.ref_clk(ref_clk),
		.rd_en(cell_rd),
		.wr_en(cell_wr),
		.addr(s_r.byte_address_field),
		.wdata(s_r.byte_value),
		.rdata(cell_rdata)
	);

	// one pass per cycle: decode the access, update the registers, then step the
	// access state; a running write freezes address and value until it is done
	always_comb begin
		s_nxt = s_r;
		{sel, off} = io_offset(io_sel, mem_sel, io_addr);
		cell_rd = 1'b0;
		cell_wr = 1'b0;
		op = IO_NONE;
		if (sel && io_wr) begin
			op = IO_WRITE;
		// bit ops reach only the lower io page
		end else if (bit_page(io_sel, io_addr) && io_bit_set) begin
			op = IO_BIT_SET;
		end else if (bit_page(io_sel, io_addr) && io_bit_clr) begin
			op = IO_BIT_CLEAR;
		end

		ctl_now = ctl_view(s_r);
		ctl_new = ctl_now;
		unique case (op)
			IO_WRITE: ctl_new = io_wdata;
			IO_BIT_SET: ctl_new[io_bit] = 1'b1;
			IO_BIT_CLEAR: ctl_new[io_bit] = 1'b0;
			IO_NONE: ctl_new = ctl_now;
		endcase
		ctl_acc = ctl_touch(op, off);
		// strobe needs master enable and no self-programming
		go_write = ctl_acc && ctl_new[`BIT_WRITE_STROBE] && s_r.master_write_enable && !self_program_busy;
		// a read strobe loses to a write strobe in the same access
		go_read = ctl_acc && ctl_new[`BIT_READ_STROBE] && !go_write;

		s_nxt.hit = sel && (io_rd || op != IO_NONE) && reg_mapped(off);
		s_nxt.rdata = 8'h00;
		if (sel && io_rd) begin
			unique case (off)
				`OFS_CONTROL: s_nxt.rdata = ctl_now;
				`OFS_VALUE: s_nxt.rdata = s_r.byte_value;
				`OFS_ADDR_LOW: s_nxt.rdata = s_r.byte_address_field[7:0];
				`OFS_ADDR_HIGH: s_nxt.rdata = {5'h00, s_r.byte_address_field[AW-1:8]};
				default: s_nxt.rdata = 8'h00;
			endcase
		end

		// address frozen while a write runs
		if (op != IO_NONE && s_r.state != ST_WRITE) begin
			if (off == `OFS_ADDR_LOW) begin
				s_nxt.byte_address_field[7:0] = ctl_new;
			end
			if (off == `OFS_ADDR_HIGH) begin
				s_nxt.byte_address_field[AW-1:8] = ctl_new[`ADDR_HIGH_BITS-1:0];
			end
		end
		if (op != IO_NONE && off == `OFS_VALUE && s_r.state == ST_IDLE) begin
			s_nxt.byte_value = ctl_new;
		end

		// master enable times out
		// the timeout closes the window even if no strobe follows
		if (s_r.master_write_enable) begin
			if (s_r.master_cnt == `MASTER_ENABLE_CYCLES - 3'h1) begin
				s_nxt.master_write_enable = 1'b0;
			end
			s_nxt.master_cnt = s_r.master_cnt + 3'h1;
		end

		if (s_r.stall_cnt != 3'h0) begin
			s_nxt.stall_cnt = s_r.stall_cnt - 3'h1;
		end

		unique case (s_r.state)
			ST_IDLE: begin
				if (ctl_acc) begin
					s_nxt.ready_interrupt_enable = ctl_new[`BIT_READY_IE];
					// a set while the window is open does not restart it
					if (ctl_new[`BIT_MASTER_ENABLE] && !s_r.master_write_enable) begin
						s_nxt.master_write_enable = 1'b1;
						s_nxt.master_cnt = 3'h0;
					end
					if (go_write) begin
						// strobe held high for the whole write
						s_nxt.write_strobe = 1'b1;
						s_nxt.master_write_enable = 1'b0;
						s_nxt.osc_cnt = 16'h0000;
						s_nxt.stall_cnt = `WRITE_STALL_CYCLES;
						s_nxt.state = ST_WRITE;
					end else if (go_read) begin
						cell_rd = 1'b1;
						s_nxt.read_strobe = 1'b1;
						s_nxt.stall_cnt = `READ_STALL_CYCLES;
						s_nxt.state = ST_READ;
					end
				end
			end
			ST_READ: begin
				// cell data was registered on the strobe edge
				s_nxt.byte_value = cell_rdata;
				s_nxt.read_strobe = 1'b0;
				s_nxt.state = ST_IDLE;
			end
			ST_WRITE: begin
				// only the interrupt enable may change meanwhile
				if (ctl_acc) begin
					s_nxt.ready_interrupt_enable = ctl_new[`BIT_READY_IE];
				end
				if (osc_tick) begin
					s_nxt.osc_cnt = s_r.osc_cnt + 16'h0001;
				end
				if (s_r.osc_cnt == 16'(WRITE_OSC_CYCLES)) begin
					// program the held byte; strobe clears
					cell_wr = 1'b1;
					s_nxt.write_strobe = 1'b0;
					s_nxt.state = ST_IDLE;
				end
			end
			default: s_nxt.state = ST_IDLE;
		endcase

		// stall drops in the cycle the counter reaches zero
		s_nxt.stall = s_nxt.stall_cnt != 3'h0;
		// level interrupt while the write strobe is zero
		s_nxt.irq = s_nxt.ready_interrupt_enable && global_int_enable && !s_nxt.write_strobe;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_r.state <= ST_IDLE;
			s_r.ready_interrupt_enable <= 1'b0;
			s_r.master_write_enable <= 1'b0;
			s_r.write_strobe <= 1'b0;
			s_r.read_strobe <= 1'b0;
			s_r.master_cnt <= 3'h0;
			s_r.stall_cnt <= 3'h0;
			s_r.osc_cnt <= 16'h0000;
			s_r.rdata <= 8'h00;
			s_r.hit <= 1'b0;
			s_r.stall <= 1'b0;
			s_r.irq <= 1'b0;
			// address and value keep their contents over reset
			s_r.byte_address_field <= s_nxt.byte_address_field;
			s_r.byte_value <= s_nxt.byte_value;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign io_rdata = s_r.rdata;
	assign io_hit = s_r.hit;
	assign stall_cpu = s_r.stall;
	assign ready_irq = s_r.irq;
endmodule : eeprom_access_controller
`default_nettype wire

// *** hw/eeprom_access_defines.svh ***
/*
 * eeprom_access_defines.svh: register offsets, field positions and timing
 * figures of the byte-wide nonvolatile store controller.
 * Assumes inclusion by bare name from files under hw/.
 */
`ifndef EEPROM_ACCESS_DEFINES_SVH
`define EEPROM_ACCESS_DEFINES_SVH

// io-space offsets (data-space address is io offset plus 0x20)
`define IO_DATA_SPACE_SHIFT 8'h20
`define IO_SPACE_LAST 8'h3F
`define IO_BIT_SPACE_LAST 8'h1F
`define EXT_IO_FIRST 8'h60
`define OFS_CONTROL 6'h1F
`define OFS_VALUE 6'h20
`define OFS_ADDR_LOW 6'h21
`define OFS_ADDR_HIGH 6'h22

// control register fields
`define CTL_READ_STROBE 1
`define CTL_WRITE_STROBE 1
`define BIT_READ_STROBE 0
`define BIT_WRITE_STROBE 1
`define BIT_MASTER_ENABLE 2
`define BIT_READY_IE 3

// address layout
`define ADDR_WIDTH 11
`define ADDR_HIGH_BITS 3

// timing
`define MASTER_ENABLE_CYCLES 3'h4
`define WRITE_STALL_CYCLES 3'h2
`define READ_STALL_CYCLES 3'h4
`define WRITE_OSC_CYCLES 27072
`define WRITE_TIME_US 3400

`endif

// *** hw/eeprom_access_pkg.sv ***
/*
 * eeprom_access_pkg.sv: types shared by the store controller.
 * Assumes eeprom_access_defines.svh is in the include path.
 */
package eeprom_access_pkg;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_READ = 2'b01,
		ST_WRITE = 2'b10
	} access_state_t;

	typedef enum logic [1:0] {
		IO_NONE = 2'b00,
		IO_WRITE = 2'b01,
		IO_BIT_SET = 2'b10,
		IO_BIT_CLEAR = 2'b11
	} io_op_t;

endpackage : eeprom_access_pkg

// *** hw/eeprom_cell_array.sv ***
/*
 * eeprom_cell_array.sv: byte array standing in for the nonvolatile cells.
 * Assumes one clock; read data comes out of a register one cycle after rd_en.
 */
`timescale 1ns/1ps
`default_nettype none
module eeprom_cell_array #(
	parameter int ADDR_W = 11,
	parameter int DEPTH = 2048
) (
	input wire logic ref_clk,
	input wire logic rd_en,
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem [DEPTH];

	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			mem[addr] <= wdata;
		end
		if (rd_en) begin
			rdata <= mem[addr];
		end
	end
endmodule : eeprom_cell_array
`default_nettype wire

// *** hw/osc_tick_divider.sv ***
/*
 * osc_tick_divider.sv: makes a one-cycle tick standing for each cycle of the
 * calibrated oscillator, counted from the core clock.
 * Assumes the core clock is faster than the oscillator.
 */
`timescale 1ns/1ps
`default_nettype none
module osc_tick_divider #(
	parameter int DIV = 5
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic run,
	output logic tick
);
	logic [15:0] cnt_r;

	always_ff @(posedge ref_clk) begin
		if (rst || !run) begin
			cnt_r <= 16'h0000;
			tick <= 1'b0;
		end else if (cnt_r == 16'(DIV - 1)) begin
			cnt_r <= 16'h0000;
			tick <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
			tick <= 1'b0;
		end
	end
endmodule : osc_tick_divider
`default_nettype wire

// *** tb/eeprom_access_props.sv ***
/*
 * eeprom_access_props.sv: port-level assertions for the store controller.
 * Assumes one clock, synchronous active-high reset, bound to the top module.
 */
`timescale 1ns/1ps
`default_nettype none
module eeprom_access_props (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic io_sel,
	input wire logic mem_sel,
	input wire logic [7:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	input wire logic global_int_enable,
	input wire logic self_program_busy,
	input wire logic [7:0] io_rdata,
	input wire logic io_hit,
	input wire logic stall_cpu,
	input wire logic ready_irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic [2:0] mwin_r;
	wire logic ctl_acc = (io_sel && io_addr == 8'h1F) || (mem_sel && io_addr == 8'h3F);
	wire logic hi_acc = (io_sel && io_addr == 8'h22) || (mem_sel && io_addr == 8'h42);
	wire logic map_acc = (io_sel && io_addr inside {[8'h1F:8'h22]}) || (mem_sel && io_addr inside {[8'h3F:8'h42]});
	wire logic ctl_wr = io_wr && ctl_acc;
	wire logic ws_go = ctl_wr && io_wdata[1] && mwin_r != 3'h0 && !self_program_busy;
	// master window mirror
	always_ff @(posedge ref_clk) begin
		if (rst) mwin_r <= 3'h0;
		else if (ws_go) mwin_r <= 3'h0;
		else if (ctl_wr && io_wdata[2] && mwin_r == 3'h0) mwin_r <= 3'h4;
		else if (mwin_r != 3'h0) mwin_r <= mwin_r - 3'h1;
	end
	sequence s_wr_stall; stall_cpu [*2] ##1 !stall_cpu; endsequence
	sequence s_rd_stall; stall_cpu [*4] ##1 !stall_cpu; endsequence
	AST_CTL_RSVD: assert property (io_rd && ctl_acc |=> io_rdata[7:4] == 4'h0) else $error("control high bits set");
	AST_HIGH_RSVD: assert property (io_rd && hi_acc |=> io_rdata[7:3] == 5'h00) else $error("address high bits set");
	AST_HIT: assert property ((io_rd || io_wr) && map_acc |=> io_hit) else $error("mapped access missed");
	AST_MISS: assert property ((io_sel || mem_sel) && !map_acc |=> !io_hit) else $error("unmapped access hit");
	AST_RDATA_IDLE: assert property (!io_rd |=> io_rdata == 8'h00) else $error("read data without read");
	AST_STALL_LEN: assert property ($rose(stall_cpu) |-> s_wr_stall or s_rd_stall) else $error("stall length wrong");
	AST_WR_STALL: assert property (ws_go |=> s_wr_stall) else $error("write start stall wrong");
	AST_NO_MASTER: assert property (ctl_wr && io_wdata[1:0] == 2'b10 && mwin_r == 3'h0 |=> !stall_cpu) else $error("strobe acted without master");
	AST_IRQ_GIE: assert property (!global_int_enable ##1 !global_int_enable |-> !ready_irq) else $error("irq without global flag");
	AST_IRQ_BUSY: assert property (ws_go |-> ##2 !ready_irq [*3]) else $error("irq during write");
endmodule : eeprom_access_props
bind eeprom_access_controller eeprom_access_props props_i (.ref_clk, .rst, .io_sel, .mem_sel, .io_addr, .io_wr,
	.io_rd, .io_wdata, .global_int_enable, .self_program_busy, .io_rdata, .io_hit, .stall_cpu, .ready_irq);
`default_nettype wire

// *** tb/cpu_core_model.sv ***
/*
 * cpu_core_model.sv: processor core issuing one io access at a time.
 * Assumes inputs change at the falling edge and read data one cycle after.
 */
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
	input wire logic ref_clk,
	input wire logic stall_cpu,
	input wire logic [7:0] io_rdata,
	output logic io_sel,
	output logic mem_sel,
	output logic [7:0] io_addr,
	output logic io_wr,
	output logic io_rd,
	output logic io_bit_set,
	output logic io_bit_clr,
	output logic [2:0] io_bit,
	output logic [7:0] io_wdata
);
	initial begin
		{io_sel, mem_sel, io_wr, io_rd, io_bit_set, io_bit_clr} = 6'h00;
		{io_addr, io_wdata, io_bit} = 19'h00000;
	end
	// op: 0 write, 1 read, 2 bit set, 3 bit clear
	task acc(input logic m, input logic [7:0] a, input logic [1:0] op, input logic [7:0] d, output logic [7:0] q);
		@(negedge ref_clk);
		while (stall_cpu === 1'b1) @(negedge ref_clk);
		io_sel = !m;
		mem_sel = m;
		io_addr = a;
		io_wdata = d;
		io_bit = d[2:0];
		{io_wr, io_rd, io_bit_set, io_bit_clr} = 4'b1000 >> op;
		@(negedge ref_clk);
		q = io_rdata;
		{io_sel, mem_sel, io_wr, io_rd, io_bit_set, io_bit_clr} = 6'h00;
		io_addr = ~io_addr;
		io_wdata = ~io_wdata;
	endtask : acc
endmodule : cpu_core_model
`default_nettype wire

// *** tb/test_eeprom_access_controller.sv ***
/*
 * test_eeprom_access_controller.sv: register-level tests of the store controller.
 * Assumes the core model and bound checker; short write time for simulation.
 */
`timescale 1ns/1ps
`default_nettype none
module test_eeprom_access_controller;
	localparam logic [7:0] CTL = 8'h1F, VAL = 8'h20, ALO = 8'h21;
	logic ref_clk, rst, global_int_enable, self_program_busy, io_sel, mem_sel, io_wr, io_rd, io_bit_set, io_bit_clr;
	logic io_hit, stall_cpu, ready_irq;
	logic [2:0] io_bit;
	logic [7:0] io_addr, io_wdata, io_rdata, q;
	int failures, cmp_count;
	eeprom_access_controller #(.OSC_DIV(5), .WRITE_OSC_CYCLES(10)) dut (.ref_clk, .rst, .io_sel, .mem_sel, .io_addr,
		.io_wr, .io_rd, .io_bit_set, .io_bit_clr, .io_bit, .io_wdata, .global_int_enable, .self_program_busy,
		.io_rdata, .io_hit, .stall_cpu, .ready_irq);
	cpu_core_model core (.ref_clk, .stall_cpu, .io_rdata, .io_sel, .mem_sel, .io_addr, .io_wr, .io_rd, .io_bit_set,
		.io_bit_clr, .io_bit, .io_wdata);
	task chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		core.acc(1'b0, a, 2'h0, d, q);
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] exp);
		core.acc(1'b0, a, 2'h1, 8'h00, q);
		chk(q, exp);
	endtask : rd
	task final_report;
		$display("comparisons %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		failures++;
		final_report;
	end
	initial begin
		{rst, global_int_enable, self_program_busy, failures, cmp_count} = {3'b100, 64'h0};
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk) rst = 1'b0;
		rd(CTL, 8'h00);
		core.acc(1'b1, 8'h42, 2'h0, 8'h07, q); // reserved bits written zero
		core.acc(1'b1, 8'h42, 2'h1, 8'h00, q);
		chk(q, 8'h07);
		chk({7'h00, io_hit}, 8'h01);
		wr(ALO, 8'hA5);
		wr(VAL, 8'h5A);
		wr(CTL, 8'h04);
		wr(CTL, 8'h02);
		wr(ALO, 8'h00);
		wr(CTL, 8'h01);
		rd(CTL, 8'h02);
		do core.acc(1'b0, CTL, 2'h1, 8'h00, q); while (q[1] === 1'b1);
		rd(ALO, 8'hA5);
		wr(VAL, 8'h00);
		wr(CTL, 8'h01);
		rd(VAL, 8'h5A);
		rd(CTL, 8'h00);
		wr(VAL, 8'h33);
		wr(CTL, 8'h02);
		rd(CTL, 8'h00);
		wr(CTL, 8'h04);
		rd(CTL, 8'h04);
		repeat (4) @(negedge ref_clk);
		wr(CTL, 8'h02);
		rd(CTL, 8'h00);
		self_program_busy = 1'b1;
		wr(CTL, 8'h04);
		wr(CTL, 8'h02);
		core.acc(1'b0, CTL, 2'h1, 8'h00, q);
		chk({7'h00, q[1]}, 8'h00);
		self_program_busy = 1'b0;
		wr(CTL, 8'h01);
		rd(VAL, 8'h5A);
		global_int_enable = 1'b1;
		core.acc(1'b0, CTL, 2'h2, 8'h03, q);
		rd(CTL, 8'h08);
		chk({7'h00, ready_irq}, 8'h01);
		core.acc(1'b0, CTL, 2'h3, 8'h03, q);
		repeat (2) @(negedge ref_clk);
		chk({7'h00, ready_irq}, 8'h00);
		global_int_enable = 1'b0;
		wr(VAL, 8'hC3);
		wr(CTL, 8'h0C);
		wr(CTL, 8'h0A);
		global_int_enable = 1'b1; // only after the strobe
		rd(CTL, 8'h0A);
		chk({7'h00, ready_irq}, 8'h00);
		do core.acc(1'b0, CTL, 2'h1, 8'h00, q); while (q[1] === 1'b1);
		chk({7'h00, ready_irq}, 8'h01);
		rd(CTL, 8'h08);
		wr(CTL, 8'h01);
		rd(VAL, 8'hC3);
		core.acc(1'b1, 8'h60, 2'h1, 8'h00, q);
		chk(q, 8'h00);
		chk({7'h00, io_hit}, 8'h00);
		final_report;
	end
endmodule : test_eeprom_access_controller
`default_nettype wire
